// >>> verilog/bkpu_top.sv
// breakpoint unit: address compare, break sequencing, APB registers
//
// Behaviour
// - break request carries vector FFFC, or FEFC in monitor mode.
// - opcode address match holds the instruction until after the break.
// - operand address match lets the instruction finish first.
// - software setting break_active breaks before the next instruction.
// - new address plus cleared break_active allows another break.
// - unchanged address after a break raises no further break.
// - status clears during break only while flag_clear_enable is one.
// - timer counter stops while a break is in progress.
// - watchdog disabled in break while high test voltage present.
// - break_enable_bit, bit 7, read/write, enables 16-bit match.
// - match sets break_active, writing one breaks, zero clears.
// - two byte registers hold break address, zero after reset.
// - wait_exit_flag reads one when break ended wait mode.
// - no address match break triggered in wait or stop modes.
// - only program counter addresses compared; match sends request.
// - return_from_interrupt in break routine ends the break state.
`timescale 1ns/100ps
module bkpu_top (
    input wire logic mclk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [bkpu_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // cpu side
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_pc_fetch_i,
    input wire logic cpu_opcode_i,
    input wire logic cpu_instr_end_i,
    input wire logic cpu_rti_i,
    input wire logic cpu_wait_i,
    input wire logic cpu_stop_i,
    input wire logic monitor_mode_i,
    input wire logic high_test_voltage_i,
    // towards system integration logic and modules
    output logic breakpoint_request_o,
    output logic hold_instr_o,
    output logic [15:0] break_vector_o,
    output logic break_in_progress_o,
    output logic timer_stop_o,
    output logic watchdog_disable_o,
    output logic flag_clear_allow_o,
    output logic irq_o
);
    import bkpu_pkg::*;

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic break_enable_bit;
        logic break_active;
        logic [7:0] break_address_high;
        logic [7:0] break_address_low;
        logic wait_exit_flag;
        logic flag_clear_enable;
        logic armed;
        logic pend;
        logic was_waiting;
        logic in_prog;
        logic req;
        logic hold;
        logic [15:0] vec;
        logic timer_stop;
        logic wdog_dis;
        logic clr_allow;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } bkpu_state_type;

    bkpu_state_type s;
    bkpu_state_type next_s;

    logic hit;
    logic wr;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic irq_en_we;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic irq_line;

    // ********************************************************
    // comparator and interrupt block
    // ********************************************************
    bkpu_cmp #(
        .AW(16)
    ) u_cmp (
        .addr_i(cpu_addr_i),
        .match_addr_i({s.break_address_high, s.break_address_low}),
        .enable_i(s.break_enable_bit),
        .pc_fetch_i(cpu_pc_fetch_i),
        .wait_i(cpu_wait_i),
        .stop_i(cpu_stop_i),
        .hit_o(hit)
    );

    bkpu_irq #(
        .W(IRQ_W)
    ) u_irq (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .set_i(irq_set),
        .clr_i(irq_clr),
        .en_we_i(irq_en_we),
        .en_wdata_i(pwdata_i[IRQ_W-1:0]),
        .status_o(irq_status),
        .enable_o(irq_enable),
        .irq_o(irq_line)
    );

    assign wr = psel_i && penable_i && s.ready && pwrite_i;
    assign irq_en_we = wr && (paddr_i == OFS_IRQ_ENABLE);
    assign irq_clr = (wr && paddr_i == OFS_IRQ_CLEAR) ?
        pwdata_i[IRQ_W-1:0] : '0;

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        logic idle;
        logic op_hit;
        logic fire;
        logic [31:0] rd;
        idle = !s.in_prog && !s.req && !s.break_active;
        op_hit = hit && idle && s.armed && !s.pend;
        fire = 1'b0;
        rd = '0;
        next_s = s;
        next_s.req = 1'b0;
        next_s.hold = 1'b0;
        irq_set = '0;

        // register writes
        if (wr) begin
            unique case (paddr_i)
                OFS_CTRL_STATUS: begin
                    next_s.break_enable_bit =
                        pwdata_i[BIT_BREAK_ENABLE];
                    next_s.break_active = pwdata_i[BIT_BREAK_ACTIVE];
                    if (pwdata_i[BIT_BREAK_ACTIVE] && idle) begin
                        next_s.pend = 1'b1;
                    end
                end
                OFS_ADDR_HIGH: begin
                    next_s.break_address_high = pwdata_i[7:0];
                    next_s.armed = 1'b1;
                end
                OFS_ADDR_LOW: begin
                    next_s.break_address_low = pwdata_i[7:0];
                    next_s.armed = 1'b1;
                end
                OFS_WAIT_STATUS: begin
                    if (!pwdata_i[BIT_WAIT_EXIT]) begin
                        next_s.wait_exit_flag = 1'b0;
                    end
                end
                OFS_FLAG_CLEAR: begin
                    next_s.flag_clear_enable = pwdata_i[BIT_FLAG_CLEAR_EN];
                end
                default: begin
                end
            endcase
        end

        // address match: opcode breaks at once, operand after completion
        if (op_hit) begin
            next_s.break_active = 1'b1;
            if (cpu_opcode_i) begin
                fire = 1'b1;
                next_s.hold = 1'b1;
            end else begin
                next_s.pend = 1'b1;
            end
        end

        // pending break taken at the instruction boundary
        if (s.pend && cpu_instr_end_i && !s.in_prog) begin
            fire = 1'b1;
        end

        if (cpu_wait_i) begin
            next_s.was_waiting = 1'b1;
        end else if (cpu_instr_end_i) begin
            next_s.was_waiting = 1'b0;
        end

        if (fire) begin
            next_s.req = 1'b1;
            next_s.pend = 1'b0;
            next_s.in_prog = 1'b1;
            next_s.armed = 1'b0;
            next_s.vec = monitor_mode_i ? VEC_MONITOR : VEC_USER;
            irq_set[IRQ_TAKEN] = 1'b1;
            if (s.was_waiting) begin
                next_s.wait_exit_flag = 1'b1;
            end
        end else if (s.in_prog && cpu_rti_i) begin
            next_s.in_prog = 1'b0;
            irq_set[IRQ_ENDED] = 1'b1;
        end

        next_s.timer_stop = next_s.in_prog;
        next_s.wdog_dis = next_s.in_prog && high_test_voltage_i;
        next_s.clr_allow = !next_s.in_prog
            || next_s.flag_clear_enable;

        // apb: zero wait states, data loaded during setup
        next_s.ready = psel_i && !penable_i;
        next_s.slverr = 1'b0;
        next_s.rdata = '0;
        if (psel_i && !penable_i) begin
            unique case (paddr_i)
                OFS_CTRL_STATUS: begin
                    rd[BIT_BREAK_ENABLE] = s.break_enable_bit;
                    rd[BIT_BREAK_ACTIVE] = s.break_active;
                end
                OFS_ADDR_HIGH: rd[7:0] = s.break_address_high;
                OFS_ADDR_LOW: rd[7:0] = s.break_address_low;
                OFS_WAIT_STATUS: rd[BIT_WAIT_EXIT] = s.wait_exit_flag;
                OFS_FLAG_CLEAR: rd[BIT_FLAG_CLEAR_EN] = s.flag_clear_enable;
                OFS_IRQ_STATUS: rd[IRQ_W-1:0] = irq_status;
                OFS_IRQ_ENABLE: rd[IRQ_W-1:0] = irq_enable;
                OFS_IRQ_CLEAR: rd = '0;
                default: next_s.slverr = 1'b1;
            endcase
            next_s.rdata = rd;
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
            s.armed <= 1'b1;
            s.clr_allow <= 1'b1;
            s.vec <= VEC_USER;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_o = s.rdata;
    assign pready_o = s.ready;
    assign pslverr_o = s.slverr;
    assign breakpoint_request_o = s.req;
    assign hold_instr_o = s.hold;
    assign break_vector_o = s.vec;
    assign break_in_progress_o = s.in_prog;
    assign timer_stop_o = s.timer_stop;
    assign watchdog_disable_o = s.wdog_dis;
    assign flag_clear_allow_o = s.clr_allow;
    assign irq_o = irq_line;

    // ********************************************************
    // assertions
    // ********************************************************
    logic break_active_seen;
    assign break_active_seen = s.break_active;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    AST_VECTOR: assert property (
        breakpoint_request_o |-> break_vector_o ==
            ($past(monitor_mode_i) ? VEC_MONITOR : VEC_USER))
        else $error("break vector wrong for mode");

    AST_OPCODE_HOLD: assert property (
        hit && cpu_opcode_i && !s.in_prog && !s.req && !s.break_active
            && s.armed && !s.pend
        |=> breakpoint_request_o && hold_instr_o && break_active_seen)
        else $error("opcode match did not hold and break");

    AST_OPERAND: assert property (
        breakpoint_request_o && !hold_instr_o |-> $past(cpu_instr_end_i))
        else $error("delayed break not at an instruction boundary");

    AST_SW_BREAK: assert property (
        s.pend && cpu_instr_end_i && !s.in_prog
        |=> breakpoint_request_o ##1 !breakpoint_request_o)
        else $error("software break not taken at boundary");

    AST_NO_REBREAK: assert property (
        !s.armed && !s.pend && !wr |=> !hold_instr_o)
        else $error("break repeated on unchanged address");

    AST_FLAG_CLR: assert property (
        break_in_progress_o && !s.flag_clear_enable |-> !flag_clear_allow_o)
        else $error("status clear allowed during break");

    AST_TIMER: assert property (
        breakpoint_request_o |-> timer_stop_o throughout
            (break_in_progress_o [*2]))
        else $error("timer not stopped during break");

    AST_WDOG: assert property (
        watchdog_disable_o |-> break_in_progress_o
            && $past(high_test_voltage_i))
        else $error("watchdog disable without break and test voltage");

    AST_LOWPWR: assert property (
        (cpu_wait_i || cpu_stop_i) && !s.pend |=> !hold_instr_o)
        else $error("break triggered in low power mode");

    AST_RTI_END: assert property (
        break_in_progress_o && cpu_rti_i && !s.req
        |=> !break_in_progress_o ##1 !timer_stop_o)
        else $error("return did not end break");

    AST_PULSE: assert property (
        breakpoint_request_o |=> !breakpoint_request_o)
        else $error("break request longer than one cycle");

    AST_DISABLED: assert property (
        !s.break_enable_bit && !s.pend |=> !breakpoint_request_o)
        else $error("break requested while breaks disabled");

    AST_WAIT_EXIT: assert property (
        breakpoint_request_o && $past(s.was_waiting) |-> s.wait_exit_flag)
        else $error("wait exit by break not flagged");

    AST_IN_PROG: assert property (
        break_in_progress_o && !cpu_rti_i |=> break_in_progress_o)
        else $error("break state ended without a return");

    COV_OPCODE: cover property (breakpoint_request_o && hold_instr_o);
    COV_DELAYED: cover property (breakpoint_request_o && !hold_instr_o);
    COV_END: cover property (break_in_progress_o ##1 !break_in_progress_o);
    COV_WAIT: cover property (!s.wait_exit_flag ##1 s.wait_exit_flag);
    COV_MON: cover property (breakpoint_request_o && s.vec == VEC_MONITOR);

endmodule : bkpu_top

// >>> verilog/bkpu_pkg.sv
// shared constants of the breakpoint unit
package bkpu_pkg;

    // ********************************************************
    // register offsets (byte addresses)
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFS_WAIT_STATUS = 8'h0C;
    localparam logic [7:0] OFS_FLAG_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int BIT_BREAK_ENABLE = 7;
    localparam int BIT_BREAK_ACTIVE = 6;
    localparam int BIT_WAIT_EXIT = 1;
    localparam int BIT_FLAG_CLEAR_EN = 7;
    localparam int IRQ_W = 2;
    localparam int IRQ_TAKEN = 0;
    localparam int IRQ_ENDED = 1;

    // ********************************************************
    // reset values and vectors
    // ********************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] VEC_USER = 16'hFFFC;
    localparam logic [15:0] VEC_MONITOR = 16'hFEFC;

endpackage : bkpu_pkg

// >>> verilog/bkpu_cmp.sv
// program address comparator of the breakpoint unit
`timescale 1ns/100ps
module bkpu_cmp #(
    parameter int AW = 16
) (
    input wire logic [AW-1:0] addr_i,
    input wire logic [AW-1:0] match_addr_i,
    input wire logic enable_i,
    input wire logic pc_fetch_i,
    input wire logic wait_i,
    input wire logic stop_i,
    output logic hit_o
);
    import bkpu_pkg::*;

    if (AW != 16) begin : g_chk
        $error("bkpu_cmp: only a 16-bit address is served");
    end

    // full compare, program counter addresses only, never in low power
    always_comb begin
        hit_o = enable_i && pc_fetch_i && !wait_i && !stop_i
            && (addr_i == match_addr_i);
    end

endmodule : bkpu_cmp

// >>> verilog/bkpu_irq.sv
// sticky event status, enable mask and interrupt line
`timescale 1ns/100ps
module bkpu_irq #(
    parameter int W = 2
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    input wire logic en_we_i,
    input wire logic [W-1:0] en_wdata_i,
    output logic [W-1:0] status_o,
    output logic [W-1:0] enable_o,
    output logic irq_o
);
    import bkpu_pkg::*;

    if (W < 1) begin : g_chk
        $error("bkpu_irq: at least one event is needed");
    end

    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] enable;
        logic irq;
    } bkpu_irq_state_type;

    bkpu_irq_state_type s;
    bkpu_irq_state_type next_s;

    always_comb begin
        next_s = s;
        // set wins over a clear in the same cycle
        next_s.status = (s.status & ~clr_i) | set_i;
        if (en_we_i) begin
            next_s.enable = en_wdata_i;
        end
        next_s.irq = |(next_s.status & next_s.enable);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign status_o = s.status;
    assign enable_o = s.enable;
    assign irq_o = s.irq;

endmodule : bkpu_irq

// >>> verif/bkpu_cpu_model.sv
// behavioural cpu core and system integration side of the breakpoint unit
`timescale 1ns/100ps
module bkpu_cpu_model (
    input wire logic mclk_i,
    input wire logic breakpoint_request_i,
    input wire logic [15:0] break_vector_i,
    output logic [15:0] cpu_addr_o,
    output logic cpu_pc_fetch_o,
    output logic cpu_opcode_o,
    output logic cpu_instr_end_o,
    output logic cpu_rti_o
);
    int n_breaks = 0;
    logic [15:0] last_vec = 16'h0000;
    initial begin
        cpu_addr_o = 16'h0000;
        cpu_pc_fetch_o = 1'b0;
        cpu_opcode_o = 1'b0;
        cpu_instr_end_o = 1'b0;
        cpu_rti_o = 1'b0;
    end
    // ********************************************************
    // vector load on each request
    // ********************************************************
    always @(posedge mclk_i) begin
        if (breakpoint_request_i === 1'b1) begin
            last_vec <= break_vector_i;
            n_breaks <= n_breaks + 1;
        end
    end
    task automatic fetch(input logic [15:0] a, input logic opc,
                         input logic pc);
        cpu_addr_o <= a;
        cpu_pc_fetch_o <= pc;
        cpu_opcode_o <= opc;
        @(posedge mclk_i);
        // bus moves on, never parks on the last address
        cpu_addr_o <= ~a;
        cpu_pc_fetch_o <= 1'b0;
        cpu_opcode_o <= ~opc;
    endtask : fetch
    task automatic boundary();
        cpu_instr_end_o <= 1'b1;
        @(posedge mclk_i);
        cpu_instr_end_o <= 1'b0;
    endtask : boundary
    task automatic return_from_interrupt();
        cpu_rti_o <= 1'b1;
        @(posedge mclk_i);
        cpu_rti_o <= 1'b0;
    endtask : return_from_interrupt
endmodule : bkpu_cpu_model

// >>> verif/tb.sv
// self-checking testbench of the breakpoint unit
`timescale 1ns/100ps
module tb;
    import bkpu_pkg::*;
    logic mclk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [15:0] cpu_addr_i, break_vector_o;
    logic cpu_pc_fetch_i, cpu_opcode_i, cpu_instr_end_i, cpu_rti_i;
    logic cpu_wait_i, cpu_stop_i, monitor_mode_i, high_test_voltage_i;
    logic breakpoint_request_o, hold_instr_o, break_in_progress_o;
    logic timer_stop_o, watchdog_disable_o, flag_clear_allow_o, irq_o, se;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    bkpu_top u_bkpu_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cpu_addr_i(cpu_addr_i),
        .cpu_pc_fetch_i(cpu_pc_fetch_i), .cpu_opcode_i(cpu_opcode_i),
        .cpu_instr_end_i(cpu_instr_end_i), .cpu_rti_i(cpu_rti_i),
        .cpu_wait_i(cpu_wait_i), .cpu_stop_i(cpu_stop_i),
        .monitor_mode_i(monitor_mode_i),
        .high_test_voltage_i(high_test_voltage_i),
        .breakpoint_request_o(breakpoint_request_o),
        .hold_instr_o(hold_instr_o), .break_vector_o(break_vector_o),
        .break_in_progress_o(break_in_progress_o),
        .timer_stop_o(timer_stop_o), .watchdog_disable_o(watchdog_disable_o),
        .flag_clear_allow_o(flag_clear_allow_o), .irq_o(irq_o));
    bkpu_cpu_model u_cpu (.mclk_i(mclk_i),
        .breakpoint_request_i(breakpoint_request_o),
        .break_vector_i(break_vector_o), .cpu_addr_o(cpu_addr_i),
        .cpu_pc_fetch_o(cpu_pc_fetch_i), .cpu_opcode_o(cpu_opcode_i),
        .cpu_instr_end_o(cpu_instr_end_i), .cpu_rti_o(cpu_rti_i));
    always #4 mclk_i = ~mclk_i;
    // ********************************************************
    // helpers
    // ********************************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic settle();
        repeat (2) @(posedge mclk_i);
    endtask : settle
    // count request pulses; check hold and vector with each
    task automatic req(input int exp, input logic hold,
                       input logic [15:0] vec);
        int cnt;
        cnt = 0;
        repeat (6) begin
            @(posedge mclk_i);
            if (breakpoint_request_o === 1'b1) begin
                cnt++;
                chk({31'h0, hold_instr_o}, {31'h0, hold});
                chk({16'h0, break_vector_o}, {16'h0, vec});
            end
        end
        chk(32'(cnt), 32'(exp));
    endtask : req
    // ********************************************************
    // tests
    // ********************************************************
    initial begin
        mclk_i = 1'b0;
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        cpu_wait_i = 1'b0;
        cpu_stop_i = 1'b0;
        monitor_mode_i = 1'b0;
        high_test_voltage_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        @(posedge mclk_i);
        rdc(OFS_CTRL_STATUS, 32'h0);
        rdc(OFS_ADDR_HIGH, 32'h0);
        rdc(OFS_ADDR_LOW, 32'h0);
        rdc(OFS_FLAG_CLEAR, 32'h0);
        rdc(8'hFC, 32'h0);
        chk({31'h0, se}, 32'h1);
        chk({31'h0, flag_clear_allow_o}, 32'h1);
        $display("test reset done");
        wr(OFS_IRQ_ENABLE, 32'h3);
        wr(OFS_ADDR_HIGH, 32'h12);
        wr(OFS_ADDR_LOW, 32'h34);
        wr(OFS_CTRL_STATUS, 32'h80);
        rdc(OFS_ADDR_LOW, 32'h34);
        rdc(OFS_CTRL_STATUS, 32'h80);
        u_cpu.fetch(16'h1234, 1'b1, 1'b0);
        req(0, 1'b0, VEC_USER);
        u_cpu.fetch(16'h1034, 1'b1, 1'b1);
        req(0, 1'b0, VEC_USER);
        u_cpu.fetch(16'h1234, 1'b1, 1'b1);
        req(1, 1'b1, VEC_USER);
        chk({31'h0, break_in_progress_o}, 32'h1);
        chk({31'h0, timer_stop_o}, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        rdc(OFS_CTRL_STATUS, 32'hC0);
        chk({31'h0, flag_clear_allow_o}, 32'h0);
        wr(OFS_FLAG_CLEAR, 32'h80);
        high_test_voltage_i <= 1'b1;
        settle();
        chk({31'h0, flag_clear_allow_o}, 32'h1);
        chk({31'h0, watchdog_disable_o}, 32'h1);
        wr(OFS_CTRL_STATUS, 32'h80);
        high_test_voltage_i <= 1'b0;
        u_cpu.return_from_interrupt();
        settle();
        chk({31'h0, break_in_progress_o}, 32'h0);
        chk({31'h0, timer_stop_o}, 32'h0);
        chk({31'h0, watchdog_disable_o}, 32'h0);
        rdc(OFS_IRQ_STATUS, 32'h3);
        wr(OFS_IRQ_CLEAR, 32'h3);
        rdc(OFS_IRQ_STATUS, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        rdc(OFS_CTRL_STATUS, 32'h80);
        $display("test opcode break done");
        u_cpu.fetch(16'h1234, 1'b1, 1'b1);
        req(0, 1'b0, VEC_USER);
        wr(OFS_ADDR_LOW, 32'h35);
        wr(OFS_IRQ_ENABLE, 32'h0);
        u_cpu.fetch(16'h1235, 1'b0, 1'b1);
        req(0, 1'b0, VEC_USER);
        u_cpu.boundary();
        req(1, 1'b0, VEC_USER);
        rdc(OFS_IRQ_STATUS, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wr(OFS_CTRL_STATUS, 32'h80);
        u_cpu.return_from_interrupt();
        wr(OFS_IRQ_CLEAR, 32'h3);
        $display("test operand break done");
        monitor_mode_i <= 1'b1;
        cpu_wait_i <= 1'b1;
        wr(OFS_CTRL_STATUS, 32'hC0);
        req(0, 1'b0, VEC_MONITOR);
        u_cpu.boundary();
        req(1, 1'b0, VEC_MONITOR);
        cpu_wait_i <= 1'b0;
        rdc(OFS_WAIT_STATUS, 32'h2);
        wr(OFS_CTRL_STATUS, 32'h80);
        u_cpu.return_from_interrupt();
        monitor_mode_i <= 1'b0;
        $display("test software break done");
        wr(OFS_ADDR_LOW, 32'h36);
        cpu_wait_i <= 1'b1;
        u_cpu.fetch(16'h1236, 1'b1, 1'b1);
        req(0, 1'b0, VEC_USER);
        cpu_wait_i <= 1'b0;
        cpu_stop_i <= 1'b1;
        u_cpu.fetch(16'h1236, 1'b1, 1'b1);
        req(0, 1'b0, VEC_USER);
        cpu_stop_i <= 1'b0;
        wr(OFS_CTRL_STATUS, 32'h0);
        u_cpu.fetch(16'h1236, 1'b1, 1'b1);
        req(0, 1'b0, VEC_USER);
        chk(32'(u_cpu.n_breaks), 32'h3);
        chk({16'h0, u_cpu.last_vec}, {16'h0, VEC_MONITOR});
        $display("test blocked break done");
        final_report();
    end
endmodule : tb
